// ---- verification/hbr_pwm_host.sv ----
`timescale 1ns/10ps
// Controller model: pins follow the asked level one clock later.
module hbr_pwm_host
(
	input wire logic sys_clk,
	input wire logic [3:0] level,
	output logic [3:0] pwmInput
);
	// Registered like a timer pin, so it never changes at the sample edge.
	always_ff @(posedge sys_clk)
	begin
		pwmInput <= level;
	end
endmodule // hbr_pwm_host

// ---- verification/hbr_router_asserts.sv ----
`timescale 1ns/10ps
// Port checker; state checks use bridge one (bit 0, state [15:14]), shoot-through and freeze checks cover all eight.
module hbr_router_asserts
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic [3:0] pwmInput,
	input wire logic [15:0] bridgeOutputState,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	input wire logic regRdEn,
	input wire logic [7:0] regRdData,
	input wire logic [7:0] gateHighOn,
	input wire logic [7:0] gateLowOn
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Output-state field of bridge one.
	wire [1:0] st1 = bridgeOutputState[15:14];
	a_hiz_both_off: assert property (clkEn && st1 == 2'h0 |=>
		!gateHighOn[0] && !gateLowOn[0]) else $error("hiz gate on");
	a_low_state_on: assert property (clkEn && st1 == 2'h1 |=>
		gateLowOn[0] && !gateHighOn[0]) else $error("low state wrong");
	a_high_state_on: assert property (clkEn && st1 == 2'h2 |=>
		gateHighOn[0] && !gateLowOn[0]) else $error("high state wrong");
	// Shoot-through would destroy the bridge, so this holds always.
	a_never_both_on: assert property ((gateHighOn & gateLowOn) == 8'h00)
		else $error("both gates on");
	a_pwm_one_side: assert property (clkEn && st1 == 2'h3 &&
		pwmInput == 4'hf |=> gateHighOn[0] ^ gateLowOn[0])
		else $error("drive side not on");
	a_freeze_gates: assert property (!clkEn |=>
		$stable(gateHighOn) && $stable(gateLowOn)) else $error("moved");
	a_unmapped_zero: assert property (clkEn && regRdEn &&
		(regAddr < 8'h0b || regAddr > 8'h0e) |=> regRdData == 8'h00)
		else $error("unmapped read not zero");
	a_read_holds: assert property (!(clkEn && regRdEn) |=>
		$stable(regRdData)) else $error("read data moved");
endmodule // hbr_router_asserts

bind hbr_router hbr_router_asserts chk (.*);

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic clkEn = 1'b1;
	logic [3:0] level = 4'h0;
	logic [3:0] pwmInput;
	logic [15:0] bridgeOutputState = 16'hffff;
	logic [7:0] regAddr = 8'h00;
	logic regWrEn = 1'b0;
	logic [7:0] regWrData = 8'h00;
	logic regRdEn = 1'b0;
	logic [7:0] regRdData, gateHighOn, gateLowOn;
	// Shadow copies of the routing registers.
	logic [15:0] src = 16'h05af;
	logic [7:0] drv = 8'h00;
	logic [7:0] fw = 8'h00;
	int n_mismatch = 0;
	int n_compared = 0;
	hbr_router #(.BRIDGES(8)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.clkEn(clkEn), .pwmInput(pwmInput),
		.bridgeOutputState(bridgeOutputState), .regAddr(regAddr),
		.regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
		.regRdData(regRdData), .gateHighOn(gateHighOn),
		.gateLowOn(gateLowOn));
	hbr_pwm_host host (.sys_clk(sys_clk), .level(level),
		.pwmInput(pwmInput));
	initial
	begin
		forever #25 sys_clk = ~sys_clk;
	end
	task check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Write strobe lasts one clock edge; shadows follow the offset.
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge sys_clk);
		regWrEn <= 1'b0;
		case (a)
			8'h0b: src[15:8] = d;
			8'h0c: src[7:0] = d;
			8'h0d: drv = d;
			8'h0e: fw = d;
			default: ;
		endcase
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge sys_clk);
		regRdEn <= 1'b0;
		#1 check({8'h00, regRdData}, {8'h00, exp});
	endtask
	// Expected gates, bridge b+1 at output bit b, register bit 7-b.
	function automatic logic [15:0] model(input logic [3:0] p);
		logic [7:0] h = 8'h00;
		logic [7:0] l = 8'h00;
		logic [1:0] c;
		logic i, o;
		for (int b = 0; b < 8; b++)
		begin
			c = bridgeOutputState[15-2*b -: 2];
			i = p[src[15-2*b -: 2]];
			o = !i && !fw[7-b];
			if (c == 2'h1) l[b] = 1'b1;
			else if (c == 2'h2) h[b] = 1'b1;
			else if (c == 2'h3)
			begin
				h[b] = drv[7-b] ? o : i;
				l[b] = drv[7-b] ? i : o;
			end
		end
		return {h, l};
	endfunction
	// Host pin lags one edge and the gates one more.
	task sweep(input string name);
		for (int p = 0; p < 16; p++)
		begin
			@(posedge sys_clk);
			level <= p[3:0];
			repeat (2) @(posedge sys_clk);
			#1 check({gateHighOn, gateLowOn}, model(p[3:0]));
		end
		$display("test %s done", name);
	endtask
	task complete_run;
		$display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(8'h0b, 8'h05);
		rd(8'h0c, 8'haf);
		rd(8'h0d, 8'h00);
		rd(8'h0e, 8'h00);
		sweep("defaults");
		wr(8'h0b, 8'h1b);
		wr(8'h0c, 8'he4);
		wr(8'h0d, 8'ha5);
		wr(8'h0e, 8'h3c);
		wr(8'h0f, 8'hff);
		rd(8'h0f, 8'h00);
		rd(8'h0d, 8'ha5);
		rd(8'h0e, 8'h3c);
		sweep("remapped");
		@(posedge sys_clk);
		bridgeOutputState <= 16'h1b1b;
		sweep("states");
		@(posedge sys_clk);
		clkEn <= 1'b0;
		wr(8'h0d, 8'hff);
		drv = 8'ha5;
		clkEn <= 1'b1;
		rd(8'h0d, 8'ha5);
		$display("test freeze done");
		complete_run();
	end
endmodule // tb_top

// ---- verilog/hbr_bridge_cell.sv ----
`timescale 1ns/10ps
`include "hbr_regs.svh"

// Gate decision for one half-bridge, purely combinational.
module hbr_bridge_cell
(
	input wire logic [3:0] pwmInput,
	input wire logic [1:0] inputSelect,
	input wire logic driveSide,
	input wire logic freewheelMode,
	input wire logic [1:0] outputState,
	output logic gateHigh,
	output logic gateLow
);

	// Level of the input this bridge follows.
	logic pwmLevel;

	// Off-phase level for the non-drive switch.
	logic freeLevel;

	// Pick one of the four inputs; code 0 is input one.
	always_comb
	begin
		pwmLevel = pwmInput[inputSelect];
	end

	// Active freewheel inverts the PWM; passive keeps the switch off.
	always_comb
	begin
		if (freewheelMode == `HBR_FW_PASSIVE)
		begin
			freeLevel = 1'b0;
		end
		else
		begin
			freeLevel = ~pwmLevel;
		end
	end

	// Output state overrides routing unless it selects PWM control.
	always_comb
	begin
		gateHigh = 1'b0;
		gateLow = 1'b0;
		case (hbr_pkg::hbr_out_state_t'(outputState))
			hbr_pkg::HBR_OUT_HIZ:
			begin
				// Both switches off, bridge floats.
				gateHigh = 1'b0;
				gateLow = 1'b0;
			end
			hbr_pkg::HBR_OUT_LOW:
			begin
				gateLow = 1'b1;
			end
			hbr_pkg::HBR_OUT_HIGH:
			begin
				gateHigh = 1'b1;
			end
			hbr_pkg::HBR_OUT_PWM:
			begin
				// Drive switch follows the input level directly.
				if (driveSide == `HBR_DRIVE_LOW_SIDE)
				begin
					gateLow = pwmLevel;
					gateHigh = freeLevel;
				end
				else
				begin
					gateHigh = pwmLevel;
					gateLow = freeLevel;
				end
			end
			default:
			begin
				gateHigh = 1'b0;
				gateLow = 1'b0;
			end
		endcase
	end

endmodule // hbr_bridge_cell

// ---- verilog/hbr_pkg.sv ----
package hbr_pkg;

	// Per-bridge output-state code, kept by another register group.
	typedef enum logic [1:0] {
		HBR_OUT_HIZ = 2'h0,
		HBR_OUT_LOW = 2'h1,
		HBR_OUT_HIGH = 2'h2,
		HBR_OUT_PWM = 2'h3
	} hbr_out_state_t;

	// Whole state of the router, registered in one process.
	typedef struct packed {
		logic [7:0] srcLow;
		logic [7:0] srcHigh;
		logic [7:0] driveSide;
		logic [7:0] freewheel;
		logic [7:0] gateHigh;
		logic [7:0] gateLow;
		logic [7:0] rdData;
	} hbr_state_t;

endpackage

// ---- verilog/hbr_regs.svh ----
`ifndef HBR_REGS_SVH
`define HBR_REGS_SVH

// Register offsets of the PWM routing block.
`define HBR_ADDR_SRC_LOW 8'h0b
`define HBR_ADDR_SRC_HIGH 8'h0c
`define HBR_ADDR_DRIVE_SIDE 8'h0d
`define HBR_ADDR_FREEWHEEL 8'h0e

// Reset values of the four routing registers.
`define HBR_RST_SRC_LOW 8'h05
`define HBR_RST_SRC_HIGH 8'haf
`define HBR_RST_DRIVE_SIDE 8'h00
`define HBR_RST_FREEWHEEL 8'h00

// Value returned for an offset this block does not own.
`define HBR_RD_UNMAPPED 8'h00

// Width of one source selector and of one output-state field.
`define HBR_SEL_W 2
`define HBR_STATE_W 2

// Field of the first bridge in a selector register (bits 7-6).
`define HBR_SEL_TOP 7

// Drive-side and freewheel bit encodings.
`define HBR_DRIVE_HIGH_SIDE 1'h0
`define HBR_DRIVE_LOW_SIDE 1'h1
`define HBR_FW_ACTIVE 1'h0
`define HBR_FW_PASSIVE 1'h1

`endif

// ---- verilog/hbr_router.sv ----
`timescale 1ns/10ps
`include "hbr_regs.svh"

// How it works
// - Two-bit selector picks input one to four.
// - First map register holds bridges one-four.
// - Second map register holds bridges five-eight.
// - Drive-side bit chooses high or low switch.
// - Drive-side register, bit 7 is bridge one.
// - Clear freewheel bit gives inverted PWM.
// - Set freewheel bit keeps opposite switch off.
// - Freewheel register, bit 7 is bridge one.
// - Routing applies only when output state is 11b.
module hbr_router
#(
	parameter int BRIDGES = 8
)
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic [3:0] pwmInput,
	input wire logic [15:0] bridgeOutputState,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	output logic [7:0] gateHighOn,
	output logic [7:0] gateLowOn
);

	// The register layout fixes the bridge count at eight.
	if (BRIDGES != 8)
	begin : g_bad_count
		$error("hbr_router supports exactly eight half-bridges.");
	end

	// Registered state of the whole block.
	hbr_pkg::hbr_state_t st_ff;

	// Next value of the registered state.
	hbr_pkg::hbr_state_t nxt_st;

	// Combinational high-side decisions from the eight bridge cells.
	logic [7:0] cellHigh;

	// Combinational low-side decisions from the bridge cells.
	logic [7:0] cellLow;

	// Outputs come directly from flip-flops in the state struct.
	assign regRdData = st_ff.rdData;
	assign gateHighOn = st_ff.gateHigh;
	assign gateLowOn = st_ff.gateLow;

	// One cell per bridge. Output bit b-1 belongs to bridge b, while
	// the registers keep bridge one in their top bits.
	for (genvar i = 0; i < 8; i++)
	begin : g_bridge
		// Top bit of this bridge's selector field in its register.
		localparam int SelHi = `HBR_SEL_TOP - 2 * (i % 4);

		// Top bit of this bridge's output-state field.
		localparam int StateHi = 15 - 2 * i;

		// Selector taken from the register that holds this bridge.
		logic [1:0] inputSelect;

		// Bridges one to four use the first map register.
		if (i < 4)
		begin : g_low
			assign inputSelect = st_ff.srcLow[SelHi -: 2];
		end
		else
		begin : g_high
			assign inputSelect = st_ff.srcHigh[SelHi -: 2];
		end

		// The cell reads the registered settings, so a write shows on
		// the gates one edge after the write edge.
		hbr_bridge_cell u_cell
		(
			.pwmInput(pwmInput),
			.inputSelect(inputSelect),
			.driveSide(st_ff.driveSide[7 - i]),
			.freewheelMode(st_ff.freewheel[7 - i]),
			.outputState(bridgeOutputState[StateHi -: 2]),
			.gateHigh(cellHigh[i]),
			.gateLow(cellLow[i])
		);
	end

	// Next-state logic: register writes, read data and gate outputs.
	// Everything holds while the clock enable is low, so a frozen
	// block keeps its gates exactly where they were.
	always_comb
	begin
		nxt_st = st_ff;
		if (clkEn)
		begin
			// Gate decisions are re-registered every enabled cycle.
			// A new setting reaches these flip-flops one cycle after
			// its write has been stored.
			nxt_st.gateHigh = cellHigh;
			nxt_st.gateLow = cellLow;

			// Register writes; unmapped offsets are ignored.
			if (regWrEn)
			begin
				case (regAddr)
					`HBR_ADDR_SRC_LOW:
					begin
						nxt_st.srcLow = regWrData;
					end
					`HBR_ADDR_SRC_HIGH:
					begin
						nxt_st.srcHigh = regWrData;
					end
					`HBR_ADDR_DRIVE_SIDE:
					begin
						nxt_st.driveSide = regWrData;
					end
					`HBR_ADDR_FREEWHEEL:
					begin
						nxt_st.freewheel = regWrData;
					end
					default:
					begin
						// Other offsets belong to other blocks.
						nxt_st.srcLow = st_ff.srcLow;
					end
				endcase
			end

			// Register reads return the stored value; the read data
			// holds until the next read. Reads see the value before a
			// write in the same cycle, which keeps the path short.
			if (regRdEn)
			begin
				case (regAddr)
					`HBR_ADDR_SRC_LOW:
					begin
						nxt_st.rdData = st_ff.srcLow;
					end
					`HBR_ADDR_SRC_HIGH:
					begin
						nxt_st.rdData = st_ff.srcHigh;
					end
					`HBR_ADDR_DRIVE_SIDE:
					begin
						nxt_st.rdData = st_ff.driveSide;
					end
					`HBR_ADDR_FREEWHEEL:
					begin
						nxt_st.rdData = st_ff.freewheel;
					end
					default:
					begin
						// Unowned offsets read as zero.
						nxt_st.rdData = `HBR_RD_UNMAPPED;
					end
				endcase
			end
		end
	end

	// State register with asynchronous reset to the documented values.
	// Gates start off so nothing switches before the first sample.
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_ff.srcLow <= `HBR_RST_SRC_LOW;
			st_ff.srcHigh <= `HBR_RST_SRC_HIGH;
			st_ff.driveSide <= `HBR_RST_DRIVE_SIDE;
			st_ff.freewheel <= `HBR_RST_FREEWHEEL;
			st_ff.gateHigh <= 8'h00;
			st_ff.gateLow <= 8'h00;
			st_ff.rdData <= 8'h00;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

endmodule // hbr_router
